/* File: design/ptio_pkg.sv */
/*
 * Shared constants for the port three and serial pin block.
 * Assumes a 25 MHz core clock and a synchronous active-low reset.
 */
package ptio_pkg;
	// Port width and reset value of the latch
	localparam int         PORT_W      = 8;
	localparam logic [7:0] LATCH_RESET = 8'h0_0ff;
	// Alternate function bit positions
	localparam int BIT_RXD  = 0;
	localparam int BIT_TXD  = 1;
	localparam int BIT_IRQ0 = 2;
	localparam int BIT_IRQ1 = 3;
	localparam int BIT_TMR0 = 4;
	localparam int BIT_TMR1 = 5;
	localparam int BIT_WR   = 6;
	localparam int BIT_RD   = 7;
	// Clock period and derived counts
	localparam int CLK_PERIOD_NS = 40;
	// Strong pull-up boost lasts two oscillator periods
	localparam int BOOST_PERIODS = 2;
	localparam int BOOST_CYCLES  = BOOST_PERIODS;
	// Glitch reject time; longest time rounds down, at least one cycle
	localparam int GLITCH_NS     = 50;
	localparam int GLITCH_RAW    = GLITCH_NS / CLK_PERIOD_NS;
	localparam int GLITCH_CYCLES = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
	// Port access kinds
	typedef enum logic [1:0] {
		PTIO_ACC_NONE,
		PTIO_ACC_READ_PIN,
		PTIO_ACC_READ_LATCH
	} ptio_acc_t;
endpackage : ptio_pkg

/* File: design/ptio_glitch_filter.sv */
/*
 * Glitch filter: output follows input only after it stays stable
 * for more than the reject length. Assumes input already synchronised.
 */
`timescale 1ns/1ps
module ptio_glitch_filter #(
	parameter int REJECT = 1
) (
	input  wire logic ref_clk_in,
	input  wire logic reset_n_in,
	input  wire logic level_in,
	output logic      level_out
);
	// Counter is eight bits wide and needs at least one cycle
	if (REJECT < 1 || REJECT > 255) begin : g_bad_reject
		$error("ptio_glitch_filter: REJECT out of range");
	end
	logic [7:0] count_q;   // Cycles the input has differed
	logic       level_q;   // Filtered level
	wire        differ = (level_in != level_q);
	wire        done   = (count_q >= 8'(REJECT));

	// Count while input differs, accept once past reject length
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			count_q <= 8'h0_000;
			level_q <= 1'b1;
		end else if (!differ) begin
			count_q <= 8'h0_000;
		end else if (done) begin
			level_q <= level_in;
			count_q <= 8'h0_000;
		end else begin
			count_q <= count_q + 8'h0_001;
		end
	end
	assign level_out = level_q;

	// A change shorter than the reject length never passes
	stable_pass_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in)
		$changed(level_q) |-> $past(level_in) == level_q)
		else $error("filter passed unstable level"); // see R9
endmodule : ptio_glitch_filter

/* File: design/ptio_port.sv */
/*
 * Port three latch, pin drivers, alternate functions and the
 * dedicated serial clock/data and slave-select pin drive.
 * Assumes a core that issues one-cycle write/read strobes and
 * external pull-ups on the open-drain style pins; pins asynchronous.
 */
// Contract
// R1: Latch one: weak pull-up, pin usable as input
// R2: Latch zero: pin driven low
// R3: Alternate function works only with latch one
// R4: Bit0 receive/data, bit1 transmit/clock
// R5: Bits 2-5 irq, timer and PWM clock inputs
// R6: Bit6 write strobe, bit7 read strobe
// R7: I2C mode: no strong pull-up, open drain
// R8: SPI mode: SPI drives strong pull-up
// R9: Filter I2C inputs, reject 50 ns glitches
// R10: I2C master: software drives serial pins
// R11: Slave select weak pull-up always on
// R12: Plain reads pin, modify reads latch
// R13: Modify instructions read latch not pin
// R14: Bit ops rewrite whole latch byte
// R15: Rising latch: strong pull-up two periods
// R16: Latch or pin onto internal bus
// R17: Latch resets to all ones
// R18: Synchronise pin inputs before use
`timescale 1ns/1ps
module ptio_port #(
	parameter int PORT_W = ptio_pkg::PORT_W
) (
	input  wire logic              ref_clk_in,
	input  wire logic              reset_n_in,
	// Core side
	input  wire logic              wr_byte_in,      // Byte write strobe
	input  wire logic [PORT_W-1:0] wr_data_in,      // Byte to write
	input  wire logic              wr_bit_in,       // Bit write strobe
	input  wire logic [2:0]        wr_bit_sel_in,   // Addressed bit
	input  wire logic              wr_bit_val_in,   // New bit value
	input  wire logic              rd_req_in,       // Read request
	input  wire logic              rd_modify_in,    // Read-modify-write
	output logic [PORT_W-1:0]      rd_data_out,     // Read answer
	output logic                   rd_valid_out,    // Answer valid
	output logic [PORT_W-1:0]      port_three_latch_out,
	// Peripheral side
	input  wire logic              uart_tx_in,      // Transmit / clock
	input  wire logic              uart_rxd_drv_in, // Mode 0 data out
	input  wire logic              xmem_wr_n_in,    // Write strobe
	input  wire logic              xmem_rd_n_in,    // Read strobe
	output logic                   uart_rxd_out,
	output logic                   ext_irq_zero_out,
	output logic                   ext_irq_one_out,
	output logic                   timer_zero_count_in_out,
	output logic                   pwm_ext_clock_in_out,
	output logic                   timer_one_count_in_out,
	// Port pins: oe low means driving low
	input  wire logic [PORT_W-1:0] port_pin_in,
	output logic [PORT_W-1:0]      port_pin_out,
	output logic [PORT_W-1:0]      port_pin_oe_n_out,
	output logic [PORT_W-1:0]      port_strong_pu_out,
	// Serial pin mode and control
	input  wire logic              serial_iface_select_in,
	input  wire logic              i2c_master_in,
	input  wire logic              sw_clock_in,     // Software clock
	input  wire logic              sw_data_in,      // Software data
	input  wire logic              spi_clock_in,
	input  wire logic              spi_data_in,
	input  wire logic              serial_clock_pin_in,
	input  wire logic              serial_data_pin_in,
	output logic                   serial_clock_pin_out,
	output logic                   serial_clock_pin_oe_n_out,
	output logic                   serial_data_pin_out,
	output logic                   serial_data_pin_oe_n_out,
	output logic                   serial_strong_pu_out,
	output logic                   i2c_clock_out,   // Filtered clock
	output logic                   i2c_data_out,    // Filtered data
	output logic                   slave_sel_pu_out
);
	if (PORT_W != 8 || ptio_pkg::BOOST_CYCLES < 1 ||
		ptio_pkg::BOOST_CYCLES > 3) begin : g_bad_cfg
		$error("ptio_port: unsupported width or boost length");
	end

	logic [PORT_W-1:0] latch_q;      // Port latch
	logic [PORT_W-1:0] latch_prev_q; // Latch one cycle earlier
	logic [PORT_W-1:0] sync1_q;      // First sync stage
	logic [PORT_W-1:0] sync2_q;      // Second sync stage
	logic [1:0]        boost_q [PORT_W]; // Boost counters
	logic [1:0]        ser_s1_q;     // Serial first stage
	logic [1:0]        ser_s2_q;     // Serial second stage

	// Merge one bit into a byte
	function automatic logic [PORT_W-1:0] set_bit(
		input logic [PORT_W-1:0] b, input logic [2:0] s,
		input logic v);
		logic [PORT_W-1:0] r;
		r    = b;
		r[s] = v;
		return r;
	endfunction : set_bit

	// Read-modify-write bit ops start from latch byte
	wire [PORT_W-1:0] bit_byte = set_bit(latch_q, wr_bit_sel_in,
		wr_bit_val_in); // see R14, R13
	wire [PORT_W-1:0] latch_d  = wr_byte_in ? wr_data_in :
		(wr_bit_in ? bit_byte : latch_q);

	// Alternate outputs gated by latch (AND is stuck low at zero)
	wire [PORT_W-1:0] alt_out = {xmem_rd_n_in, xmem_wr_n_in, 4'h0_00f,
		uart_tx_in, uart_rxd_drv_in}; // see R4, R6
	wire [PORT_W-1:0] drive   = latch_q & alt_out; // see R3

	// Latch and sync registers
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			latch_q      <= ptio_pkg::LATCH_RESET; // see R17
			latch_prev_q <= ptio_pkg::LATCH_RESET;
			sync1_q      <= ptio_pkg::LATCH_RESET;
			sync2_q      <= ptio_pkg::LATCH_RESET;
		end else begin
			latch_q      <= latch_d;
			latch_prev_q <= latch_q;
			sync1_q      <= port_pin_in;  // see R18
			sync2_q      <= sync1_q;
		end
	end

	assign port_three_latch_out = latch_q; // see R16

	// Pin drive: zero pulls low, one releases to pull-up
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			port_pin_out      <= '0;
			port_pin_oe_n_out <= '1;
		end else begin
			port_pin_out      <= '0;           // see R2
			port_pin_oe_n_out <= drive;        // see R1
		end
	end

	// Strong pull-up boost after a rising latch bit, one process
	wire [PORT_W-1:0] rise = latch_q & ~latch_prev_q; // see R15
	always_ff @(posedge ref_clk_in) begin
		for (int i = 0; i < PORT_W; i++) begin
			if (!reset_n_in) begin
				boost_q[i]            <= 2'h0_0;
				port_strong_pu_out[i] <= 1'b0;
			end else begin
				if (rise[i])
					boost_q[i] <= 2'(ptio_pkg::BOOST_CYCLES);
				else if (boost_q[i] != 2'h0_0)
					boost_q[i] <= boost_q[i] - 2'h0_1;
				port_strong_pu_out[i] <= rise[i] || (boost_q[i] > 2'h0_1);
			end
		end
	end
	for (genvar i = 0; i < PORT_W; i++) begin : g_boost
		boost_len_a: assert property (@(posedge ref_clk_in)
			disable iff (!reset_n_in)
			$rose(port_strong_pu_out[i]) |=> port_strong_pu_out[i]
			##1 !port_strong_pu_out[i] || latch_q[i] != latch_prev_q[i])
			else $error("boost length wrong"); // see R15
	end

	// Read answer: latch for modify, pin otherwise
	wire [PORT_W-1:0] rd_sel = rd_modify_in ? latch_q : sync2_q;
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			rd_data_out  <= '0;
			rd_valid_out <= 1'b0;
		end else begin
			rd_data_out  <= rd_sel;         // see R12, R16
			rd_valid_out <= rd_req_in;
		end
	end

	// Alternate inputs: pin level where latch allows, else zero
	wire [PORT_W-1:0] alt_in = sync2_q & latch_q; // see R3, R18
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			uart_rxd_out            <= 1'b0;
			ext_irq_zero_out        <= 1'b0;
			ext_irq_one_out         <= 1'b0;
			timer_zero_count_in_out <= 1'b0;
			pwm_ext_clock_in_out    <= 1'b0;
			timer_one_count_in_out  <= 1'b0;
		end else begin
			uart_rxd_out            <= alt_in[ptio_pkg::BIT_RXD];
			ext_irq_zero_out        <= alt_in[ptio_pkg::BIT_IRQ0];
			ext_irq_one_out         <= alt_in[ptio_pkg::BIT_IRQ1];
			timer_zero_count_in_out <= alt_in[ptio_pkg::BIT_TMR0];
			pwm_ext_clock_in_out    <= alt_in[ptio_pkg::BIT_TMR0];
			timer_one_count_in_out  <= alt_in[ptio_pkg::BIT_TMR1];
		end // see R5
	end

	// Serial pins: SPI push-pull, I2C open drain or software control
	wire clk_src = (!serial_iface_select_in && i2c_master_in) ?
		sw_clock_in : spi_clock_in; // see R10
	wire dat_src = (!serial_iface_select_in && i2c_master_in) ?
		sw_data_in : spi_data_in;
	wire spi_on  = serial_iface_select_in;
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			serial_clock_pin_out      <= 1'b0;
			serial_clock_pin_oe_n_out <= 1'b1;
			serial_data_pin_out       <= 1'b0;
			serial_data_pin_oe_n_out  <= 1'b1;
			serial_strong_pu_out      <= 1'b0;
			slave_sel_pu_out          <= 1'b1;
		end else begin
			serial_clock_pin_out      <= spi_on & clk_src; // see R8
			serial_clock_pin_oe_n_out <= spi_on ? 1'b0 : clk_src; // see R7
			serial_data_pin_out       <= spi_on & dat_src;
			serial_data_pin_oe_n_out  <= spi_on ? 1'b0 : dat_src;
			serial_strong_pu_out      <= spi_on & clk_src;
			slave_sel_pu_out          <= 1'b1;             // see R11
		end
	end

	// Serial inputs synchronised then filtered for I2C
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			ser_s1_q <= 2'h0_3;
			ser_s2_q <= 2'h0_3;
		end else begin
			ser_s1_q <= {serial_data_pin_in, serial_clock_pin_in};
			ser_s2_q <= ser_s1_q; // see R18
		end
	end
	logic clk_f;
	logic dat_f;
	ptio_glitch_filter #(.REJECT(ptio_pkg::GLITCH_CYCLES)) u_fclk (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.level_in   (ser_s2_q[0]),
		.level_out  (clk_f)); // see R9
	ptio_glitch_filter #(.REJECT(ptio_pkg::GLITCH_CYCLES)) u_fdat (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.level_in   (ser_s2_q[1]),
		.level_out  (dat_f));
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			i2c_clock_out <= 1'b1;
			i2c_data_out  <= 1'b1;
		end else begin
			i2c_clock_out <= clk_f;
			i2c_data_out  <= dat_f;
		end
	end

	// Every zero latch bit pulls its pin low one cycle later
	low_drive_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in)
		1'b1 |=> (port_pin_oe_n_out & ~$past(latch_q)) == '0)
		else $error("zero latch not driven low"); // see R2
	// Modify reads return the latch one cycle later
	rmw_latch_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in)
		rd_req_in && rd_modify_in |=> rd_valid_out &&
		rd_data_out == $past(latch_q))
		else $error("modify read not latch"); // see R13
	// Plain reads return the synchronised pin
	pin_read_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in)
		rd_req_in && !rd_modify_in |=> rd_data_out == $past(sync2_q))
		else $error("pin read wrong"); // see R12
	// Bit write changes only the addressed bit
	bit_write_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in)
		wr_bit_in && !wr_byte_in |=> latch_q ==
		set_bit($past(latch_q), $past(wr_bit_sel_in),
		$past(wr_bit_val_in)))
		else $error("bit write disturbed byte"); // see R14
	// Gated alternate input reads zero when latch bit is zero
	alt_gate_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in)
		!latch_q[ptio_pkg::BIT_IRQ0] |=> !ext_irq_zero_out)
		else $error("alternate input not gated"); // see R3
	// I2C mode never enables strong pull-up
	i2c_open_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in)
		!serial_iface_select_in |=> !serial_strong_pu_out &&
		!serial_clock_pin_out)
		else $error("strong pull-up in I2C mode"); // see R7
	// SPI mode always drives data pin
	spi_push_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in)
		serial_iface_select_in |=> !serial_data_pin_oe_n_out &&
		serial_data_pin_out == $past(spi_data_in))
		else $error("SPI pin not push-pull"); // see R8
	// Slave-select pull-up stays on
	ss_pullup_a: assert property (@(posedge ref_clk_in)
		disable iff (!reset_n_in) slave_sel_pu_out)
		else $error("slave select pull-up off"); // see R11
endmodule : ptio_port

/* File: sim/ptio_pin_model.sv */
/*
 * Board model: pull-ups and external pull-downs on port and serial pins.
 * Assumes an enable that is low while the device drives the pin.
 */
`timescale 1ns/1ps
module ptio_pin_model (
	input  wire logic [7:0] oe_n_in,    // Port drive enables
	input  wire logic [7:0] drv_in,     // Port drive levels
	input  wire logic [7:0] ext_low_in, // Outside pull-downs
	input  wire logic [1:0] s_oe_n_in,  // Serial drive enables
	input  wire logic [1:0] s_drv_in,   // Serial drive levels
	input  wire logic [1:0] s_low_in,   // Outside serial pull-downs
	output logic      [7:0] level_out,  // Resolved port pins
	output logic      [1:0] s_level_out // Resolved serial pins
);
	// Driven pin shows the drive, released pin rests on its pull-up unless an outside pull-down holds it low
	assign level_out = ~oe_n_in & drv_in | oe_n_in & ~ext_low_in;
	// Same resolution for clock (bit 0) and data (bit 1)
	assign s_level_out = ~s_oe_n_in & s_drv_in | s_oe_n_in & ~s_low_in;
endmodule : ptio_pin_model

/* File: sim/port3_and_serial_pin_io_tb.sv */
/*
 * Self-checking bench for the port three block.
 * Assumes the pin model in the same folder and the design package.
 */
`timescale 1ns/1ps
module port3_and_serial_pin_io_tb;
	logic       clk = 0, rst_n = 0;   // Clock and reset
	logic       wr_byte, wr_bit, bit_val, rd_req, rd_mod, rd_valid;
	logic [2:0] bit_sel;              // Addressed bit
	logic [7:0] wr_data, rd_data, lat, am, lv, ext, pin_lv, pin_o, oe_n, spu;
	logic       tx, rxd_drv, wr_n, rd_n, rxd, irq0, irq1, tmr0, pwm, tmr1;
	logic       sel, mst, sw_c, sw_d, spi_c, spi_d, sc_o, sc_oe, sd_o, sd_oe;
	logic       s_spu, i2c_c, i2c_d, ss_pu, acc;
	logic [1:0] s_low, s_lv;          // Serial pull-downs and levels
	logic [7:0] lat_o;                // Latch as shown outside
	int         seed = 13962;         // Fixed random seed
	int         bad_count = 0, samples_checked = 0, n;
	// 25 MHz core clock
	always #20 clk = ~clk;
	ptio_port u_ptio_port (.ref_clk_in(clk), .reset_n_in(rst_n),
		.wr_byte_in(wr_byte), .wr_data_in(wr_data), .wr_bit_in(wr_bit),
		.wr_bit_sel_in(bit_sel), .wr_bit_val_in(bit_val), .rd_req_in(rd_req),
		.rd_modify_in(rd_mod), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
		.port_three_latch_out(lat_o), .uart_tx_in(tx),
		.uart_rxd_drv_in(rxd_drv),
		.xmem_wr_n_in(wr_n), .xmem_rd_n_in(rd_n), .uart_rxd_out(rxd),
		.ext_irq_zero_out(irq0), .ext_irq_one_out(irq1),
		.timer_zero_count_in_out(tmr0), .pwm_ext_clock_in_out(pwm),
		.timer_one_count_in_out(tmr1), .port_pin_in(pin_lv),
		.port_pin_out(pin_o), .port_pin_oe_n_out(oe_n),
		.port_strong_pu_out(spu), .serial_iface_select_in(sel),
		.i2c_master_in(mst), .sw_clock_in(sw_c), .sw_data_in(sw_d),
		.spi_clock_in(spi_c), .spi_data_in(spi_d),
		.serial_clock_pin_in(s_lv[0]), .serial_data_pin_in(s_lv[1]),
		.serial_clock_pin_out(sc_o), .serial_clock_pin_oe_n_out(sc_oe),
		.serial_data_pin_out(sd_o), .serial_data_pin_oe_n_out(sd_oe),
		.serial_strong_pu_out(s_spu), .i2c_clock_out(i2c_c),
		.i2c_data_out(i2c_d), .slave_sel_pu_out(ss_pu));
	ptio_pin_model u_ptio_pin_model (.oe_n_in(oe_n), .drv_in(pin_o),
		.ext_low_in(ext), .s_oe_n_in({sd_oe, sc_oe}), .s_drv_in({sd_o, sc_o}),
		.s_low_in(s_low), .level_out(pin_lv), .s_level_out(s_lv));
	// Compare and count
	task automatic check(input string nm, input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Step past edges, inputs change just after
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask : tick
	// One-cycle byte write
	task automatic wbyte(input logic [7:0] d);
		wr_byte = 1;
		wr_data = d;
		tick(1);
		wr_byte = 0;
		lat = d;
	endtask : wbyte
	// One-cycle read, answer checked in the cycle it stands
	task automatic rd(input logic m, input string nm, input logic [7:0] e);
		rd_req = 1;
		rd_mod = m;
		tick(1);
		rd_req = 0;
		check("read valid", rd_valid, 1);
		check(nm, rd_data, e);
		tick(1);
		check("valid drop", rd_valid, 0);
	endtask : rd
	// Verdict
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	// Main sequence
	initial begin
		{wr_byte, wr_bit, bit_val, rd_req, rd_mod, bit_sel, wr_data} = 0;
		{tx, rxd_drv, wr_n, rd_n, mst, sw_c, sw_d} = 7'h7f;
		{sel, spi_c, spi_d, ext, s_low} = 0;
		repeat (12) @(posedge clk);
		#2 rst_n = 1;
		tick(2);
		check("oe after reset", oe_n, 8'h00ff);
		check("ss pull-up", ss_pu, 1);
		rd(1, "latch after reset", 8'h00ff);
		check("latch out reset", lat_o, 8'h00ff);
		// Random latch, alternate outputs and outside pull-downs
		repeat (24) begin
			{tx, rxd_drv, wr_n, rd_n} = $random(seed);
			ext = $random(seed);
			wbyte($random(seed));
			am = {rd_n, wr_n, 4'hf, tx, rxd_drv};
			lv = lat & am & ~ext;
			tick(3);
			check("pin drive", oe_n, lat & am);
			check("pin level", pin_o, 8'h0000);
			check("latch out", lat_o, lat);
			rd(1, "latch read", lat);
			rd(0, "pin read", lv);
			check("alt inputs", {tmr1, pwm, tmr0, irq1, irq0, rxd},
				{lv[5], lv[4], lv[4], lv[3], lv[2], lv[0]});
			bit_sel = $random(seed);
			bit_val = $random(seed);
			wr_bit = 1;
			tick(1);
			wr_bit = 0;
			lat[bit_sel] = bit_val;
			rd(1, "bit write", lat);
		end
		// Boost on rising latch bits: total high cycles over all bits
		ext = 0;
		wbyte(8'h0000);
		tick(3);
		wbyte(8'h00a5);
		n = 0;
		repeat (8) begin
			n += $countones(spu);
			tick(1);
		end
		check("boost", n, 4 * ptio_pkg::BOOST_CYCLES);
		// Push-pull serial pins under SPI control
		sel = 1;
		for (int i = 0; i < 4; i++) begin
			{spi_d, spi_c} = i;
			tick(3);
			check("spi pins", s_lv, i);
			check("spi drive", {sd_oe, sc_oe, s_spu}, {2'b00, spi_c});
		end
		// Software levels on open-drain pins
		sel = 0;
		for (int i = 0; i < 4; i++) begin
			{sw_d, sw_c} = i;
			tick(3);
			check("sw pins", s_lv, i);
			check("i2c drive", {sd_oe, sc_oe, s_spu}, {i[1:0], 1'b0});
		end
		// One-cycle glitch rejected, long low passed
		s_low = 2'b10;
		tick(1);
		s_low = 0;
		acc = 1;
		repeat (8) begin
			acc &= i2c_d;
			tick(1);
		end
		check("glitch", acc, 1);
		// Two-cycle low outlasts the reject time and must pass
		s_low = 2'b10;
		tick(2);
		s_low = 0;
		acc = 1;
		repeat (8) begin
			acc &= i2c_d;
			tick(1);
		end
		check("short low", acc, 0);
		s_low = 2'b11;
		tick(8);
		check("filtered low", {i2c_d, i2c_c}, 0);
		stop_test();
	end
endmodule : port3_and_serial_pin_io_tb
